/* File: verif/comm_area_model.sv */
// shared area memory model: acknowledges the frame count write lag+1 cycles after the request rises
`timescale 1ns/1ps
module comm_area_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [3:0] lag,
  input  wire       comm_write_req,
  output reg        comm_write_done
);
  reg [3:0] wait_reg;
  // done is a one-cycle pulse so a stuck request shows as a hang, not a pass
  always @(posedge aclk) begin
    if (!aresetn || !comm_write_req || comm_write_done) begin
      wait_reg <= 4'h0;
      comm_write_done <= 1'b0;
    end else if (wait_reg == lag) begin
      comm_write_done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

/* File: verif/frame_timing_properties.sv */
// checker of frame timing port behaviour
`timescale 1ns/1ps
module frame_timing_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        xfer_busy,
  input wire        slow_request,
  input wire        comm_write_done,
  input wire        comm_write_req,
  input wire [15:0] comm_write_data,
  input wire        sof_send,
  input wire        periodic_priority,
  input wire        slow_start_ok,
  input wire        frame_start_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the request waits one cycle after the start-of-frame pulse before it rises
  a_sof_req:
    assert property (sof_send |-> ##2 comm_write_req)
    else $error("no write-back after sof");
  a_req_hold:
    assert property (comm_write_req && !comm_write_done |=> comm_write_req)
    else $error("write-back request dropped early");
  a_data_hold:
    assert property (comm_write_req && $past(comm_write_req) |-> $stable(comm_write_data))
    else $error("write-back data moved");
  a_flag_set:
    assert property (comm_write_req && comm_write_done |=> frame_start_flag && !comm_write_req)
    else $error("flag not set after write-back");
  a_flag_cause:
    assert property ($rose(frame_start_flag) |-> $past(comm_write_req && comm_write_done))
    else $error("flag set without write-back");
  a_prio_idle:
    assert property ($rose(periodic_priority) |-> !$past(xfer_busy))
    else $error("priority taken during transfer");
  a_slow_cause:
    assert property (slow_start_ok |-> $past(slow_request))
    else $error("slow start without request");
  a_rvalid_drop:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_bvalid_drop:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  cover property (comm_write_req && comm_write_done);
  cover property ($rose(periodic_priority));
  cover property (slow_start_ok);
endmodule
bind frame_timing frame_timing_checker chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .xfer_busy(xfer_busy), .slow_request(slow_request), .comm_write_done(comm_write_done),
  .comm_write_req(comm_write_req), .comm_write_data(comm_write_data), .sof_send(sof_send),
  .periodic_priority(periodic_priority), .slow_start_ok(slow_start_ok),
  .frame_start_flag(frame_start_flag));

/* File: verif/tb_usb_host_frame_timing_hub_desc.sv */
// bench for frame timing, periodic start, threshold and hub descriptor
`timescale 1ns/1ps
`include "frame_timing_regs.vh"
module tb_usb_host_frame_timing_hub_desc;
  reg         aclk = 1'b0, aresetn = 1'b0, xfer_busy = 1'b0, slow_request = 1'b0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata = 32'h0000_0000, rd_data;
  reg  [3:0]  lag = 4'h0;
  reg  [3:0]  wstrb = 4'hf;
  reg  [1:0]  rd_resp;
  wire        awready, wready, bvalid, arready, rvalid, done, req, sof, prio, slow_ok, flag;
  wire [1:0]  bresp, rresp, port_power;
  wire [31:0] rdata;
  wire [15:0] cw_data;
  integer     num_errors = 0, checks = 0, cycles = 0, sofs = 0;
  always #2 aclk = ~aclk;
  always @(posedge aclk) if (sof) sofs <= sofs + 1;
  frame_timing #(.PORTS(2), .PORT_COUNT(8'h01)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .xfer_busy(xfer_busy), .slow_request(slow_request), .comm_write_done(done),
    .comm_write_req(req), .comm_write_data(cw_data), .sof_send(sof),
    .periodic_priority(prio), .slow_start_ok(slow_ok), .frame_start_flag(flag),
    .port_power(port_power));
  comm_area_model far (.aclk(aclk), .aresetn(aresetn), .lag(lag),
    .comm_write_req(req), .comm_write_done(done));
  task give_verdict;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // a hang anywhere ends here instead of running forever
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    reg waiting;
    begin
      waiting = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      while (waiting) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (arready) arvalid <= 1'b0;
        if (w ? bvalid : rvalid) begin
          waiting = 1'b0;
          rd_data = rdata;
          rd_resp = w ? bresp : rresp;
          bready <= 1'b0;
          rready <= 1'b0;
        end
      end
    end
  endtask
  task rc(input [11:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0000_0000);
      check($sformatf("reg %h", a), rd_data, exp);
    end
  endtask
  task wc(input [11:0] wa, input [31:0] d, input [11:0] ra, input [31:0] exp);
    begin
      bus(1'b1, wa, d);
      rc(ra, exp);
    end
  endtask
  task wait_sof;
    integer n;
    begin
      n = sofs;
      while (sofs == n) @(posedge aclk);
      repeat (3) @(posedge aclk);
    end
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFS_FRAME_COUNT, 32'h0000_0000);
    rc(`OFS_PERIODIC_START, 32'h0000_0000);
    rc(`OFS_SLOW_THRESHOLD, 32'h0000_0628);
    rc(`OFS_HUB_DESC_FIRST, 32'h0200_1201);
    rc(`OFS_FRAME_PERIOD, 32'h0000_2edf);
    bus(1'b0, 12'h0ff0, 32'h0000_0000);
    check("unmapped resp", rd_resp, 32'h0000_0002);
    bus(1'b1, 12'h0ff0, 32'hffff_ffff);
    check("unmapped write resp", rd_resp, 32'h0000_0002);
    wc(`OFS_FRAME_COUNT, 32'hffff_ffff, `OFS_FRAME_COUNT, 32'h0000_0000);
    wc(`OFS_PORT_MASK, 32'h0000_0004, `OFS_PORT_MASK, 32'h0000_0004);
    // power readback sits in the port select field, port 0 at bit 8, port 1 at bit 9
    wc(`OFS_POWER_CMD, 32'h0000_0304, `OFS_POWER_CMD, 32'h0000_0200);
    wc(`OFS_POWER_CMD, 32'h0000_0001, `OFS_POWER_CMD, 32'h0000_0300);
    wc(`OFS_POWER_CMD, 32'h0000_0002, `OFS_POWER_CMD, 32'h0000_0200);
    wc(`OFS_POWER_CMD, 32'h0000_0308, `OFS_POWER_CMD, 32'h0000_0000);
    wc(`OFS_HUB_DESC_FIRST, 32'h0200_1001, `OFS_HUB_DESC_FIRST, 32'h0200_1001);
    wc(`OFS_POWER_CMD, 32'h0000_0001, `OFS_POWER_CMD, 32'h0000_0300);
    wc(`OFS_POWER_CMD, 32'h0000_0002, `OFS_POWER_CMD, 32'h0000_0000);
    wc(`OFS_HUB_DESC_FIRST, 32'h0200_1101, `OFS_POWER_CMD, 32'h0000_0300);
    check("port power", port_power, 32'h0000_0003);
    wc(`OFS_HUB_DESC_FIRST, 32'hffff_ffff, `OFS_HUB_DESC_FIRST, 32'hff00_1b01);
    wc(`OFS_PERIODIC_START, 32'hffff_ffff, `OFS_PERIODIC_START, 32'h0000_3fff);
    wc(`OFS_PERIODIC_START, 32'h0000_2a3f, `OFS_PERIODIC_START, 32'h0000_2a3f);
    wc(`OFS_SLOW_THRESHOLD, 32'hffff_ffff, `OFS_SLOW_THRESHOLD, 32'h0000_0fff);
    // a partial word must leave the field untouched
    wstrb <= 4'h1;
    wc(`OFS_SLOW_THRESHOLD, 32'h0000_0001, `OFS_SLOW_THRESHOLD, 32'h0000_0fff);
    wstrb <= 4'hf;
    wc(`OFS_FRAME_PERIOD, 32'h0000_0007, `OFS_FRAME_PERIOD, 32'h0000_0007);
    xfer_busy <= 1'b1;
    slow_request <= 1'b1;
    wc(`OFS_CONTROL, 32'h0000_0001, `OFS_FRAME_COUNT, 32'h0000_0001);
    wait_sof;
    check("priority", prio, 32'h0000_0000);
    check("slow ok", slow_ok, 32'h0000_0000);
    xfer_busy <= 1'b0;
    repeat (3) @(posedge aclk);
    check("priority", prio, 32'h0000_0001);
    lag <= 4'hf;
    wc(`OFS_SLOW_THRESHOLD, 32'h0000_0000, `OFS_STATUS, 32'h0000_0003);
    check("slow ok", slow_ok, 32'h0000_0001);
    wc(`OFS_STATUS, 32'h0000_0001, `OFS_STATUS, 32'h0000_0002);
    while (!(req && done)) @(posedge aclk);
    check("shared data", cw_data, sofs);
    repeat (2) @(posedge aclk);
    check("frame flag", flag, 32'h0000_0001);
    wait_sof;
    wait_sof;
    rc(`OFS_FRAME_COUNT, sofs);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`OFS_FRAME_PERIOD, 32'h0000_2edf);
    rc(`OFS_PERIODIC_START, 32'h0000_0000);
    give_verdict;
  end
endmodule

/* File: verilog/frame_bit_timer.v */
// bit-time strobe generator from the controller clock
`timescale 1ns/1ps
module frame_bit_timer #(
  parameter [7:0] CYCLES = 8'd20
) (
  input  wire aclk,
  input  wire aresetn,
  output reg  bit_tick
);
  reg [7:0] count_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 8'h00;
      bit_tick  <= 1'b0;
    end else if (count_reg == CYCLES - 8'd1) begin
      count_reg <= 8'h00;
      bit_tick  <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'd1;
      bit_tick  <= 1'b0;
    end
  end
endmodule

/* File: verilog/frame_timing.v */
// frame counter, periodic start, slow threshold and root hub descriptor with axi4-lite slave
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "frame_timing_regs.vh"
// Notes on behaviour
// - frame count increments on reload, wraps
// - entering running state bumps frame count
// - write count to shared area after sof
// - set frame start flag after write-back
// - periodic start clears on reset, software-written
// - periodic lists win at periodic start
// - finish current control/bulk transaction first
// - slow transaction only if left >= threshold
// - overcurrent absent resets to one
// - overcurrent mode: collective or per-port
// - overcurrent mode follows switch mode at reset (here it resets to zero while switch mode resets to one)
// - compound bit reads zero, writes ignored
// - switch mode zero powers ports together
// - masked ports obey only per-port commands
// - unmasked ports obey only global commands
// - always-on flag resets zero, selects switching
// - port count read-only, resets to one
// - frame left counts bit times, reloads
// - frame period resets to nominal
module frame_timing #(
  parameter       PORTS      = 1,
  parameter [7:0] PORT_COUNT = `RST_PORT_COUNT
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [11:0]      s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [11:0]      s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             xfer_busy,
  input  wire             slow_request,
  input  wire             comm_write_done,
  output reg              comm_write_req,
  output reg  [15:0]      comm_write_data,
  output reg              sof_send,
  output reg              periodic_priority,
  output reg              slow_start_ok,
  output reg              frame_start_flag,
  output reg  [PORTS-1:0] port_power
);
  localparam S_IDLE  = 3'b001;
  localparam S_WBACK = 3'b010;
  localparam S_WAIT  = 3'b100;
  wire        bit_tick;
  reg  [15:0] frame_count_reg;
  reg  [13:0] frame_left_reg;
  reg  [13:0] frame_period_reg;
  reg  [13:0] periodic_start_reg;
  reg  [11:0] slow_threshold_reg;
  reg  [7:0]  power_good_reg;
  reg         oc_absent_reg;
  reg         oc_mode_reg;
  reg         switch_mode_reg;
  reg         always_on_reg;
  reg         running_reg;
  reg         running_d_reg;
  reg  [PORTS-1:0] mask_reg;
  reg  [2:0]  state_reg;
  reg         pend_reg;
  reg  [11:0] awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_have_reg;
  reg         w_have_reg;
  reg  [31:0] rd_next;
  reg         rd_ok;
  wire        reload;
  wire        enter_run;
  wire        do_write;
  wire        full_word;
  frame_bit_timer #(
    .CYCLES (8'd20)
  ) u_bit_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .bit_tick (bit_tick)
  );
  assign reload    = running_reg && bit_tick && (frame_left_reg == 14'h0000);
  assign enter_run = running_reg && !running_d_reg;
  assign do_write  = aw_have_reg && w_have_reg && !s_axi_bvalid;
  // partial writes are ignored whole; fields span bytes so require all set
  assign full_word = (wstrb_reg == 4'hf);
  // write channel: address and data in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg    <= s_axi_awaddr;
        aw_have_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        w_have_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        case (awaddr_reg)
          `OFS_PERIODIC_START, `OFS_SLOW_THRESHOLD, `OFS_HUB_DESC_FIRST, `OFS_FRAME_PERIOD,
          `OFS_CONTROL, `OFS_POWER_CMD, `OFS_PORT_MASK, `OFS_FRAME_COUNT, `OFS_FRAME_LEFT,
          `OFS_STATUS: s_axi_bresp <= 2'b00;
          default:     s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // software-writable fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      periodic_start_reg <= 14'h0000;
      slow_threshold_reg <= `RST_SLOW_THRESHOLD;
      frame_period_reg   <= `RST_FRAME_PERIOD;
      power_good_reg     <= `RST_POWER_GOOD;
      oc_absent_reg      <= `RST_OC_ABSENT;
      // collective reporting pairs with ganged; reset switch mode is individual though,
      // the mode stays zero as printed and software aligns the pair
      oc_mode_reg        <= `RST_OC_MODE;
      switch_mode_reg    <= `RST_SWITCH_MODE;
      always_on_reg      <= `RST_ALWAYS_ON;
      running_reg        <= 1'b0;
      mask_reg           <= {PORTS{1'b0}};
      port_power         <= {PORTS{1'b0}};
    end else begin
      if (always_on_reg) begin
        port_power <= {PORTS{1'b1}};
      end
      if (do_write && full_word) begin
        case (awaddr_reg)
          `OFS_PERIODIC_START: periodic_start_reg <= wdata_reg[13:0];
          `OFS_SLOW_THRESHOLD: slow_threshold_reg <= wdata_reg[11:0];
          `OFS_FRAME_PERIOD:   frame_period_reg   <= wdata_reg[13:0];
          `OFS_HUB_DESC_FIRST: begin
            power_good_reg  <= wdata_reg[31:24];
            oc_absent_reg   <= wdata_reg[`BIT_OC_ABSENT];
            oc_mode_reg     <= wdata_reg[`BIT_OC_MODE];
            switch_mode_reg <= wdata_reg[`BIT_SWITCH_MODE];
            always_on_reg   <= wdata_reg[`BIT_ALWAYS_ON];
            // compound bit and port count are not stored
          end
          `OFS_CONTROL:   running_reg <= wdata_reg[0];
          `OFS_PORT_MASK: mask_reg    <= wdata_reg[PORTS:1];
          `OFS_POWER_CMD: begin
            // bits: 0 global on, 1 global off, 2 port on, 3 port off; port select in [15:8]
            if (!always_on_reg) begin
              if (!switch_mode_reg) begin
                if (wdata_reg[0]) port_power <= {PORTS{1'b1}};
                if (wdata_reg[1]) port_power <= {PORTS{1'b0}};
              end else begin
                port_power <= (port_power & (mask_reg | ~{PORTS{wdata_reg[1]}}))
                            | (~mask_reg & {PORTS{wdata_reg[0]}});
                if (wdata_reg[2]) port_power <= port_power | (mask_reg & wdata_reg[PORTS+7:8]);
                if (wdata_reg[3]) port_power <= port_power & ~(mask_reg & wdata_reg[PORTS+7:8]);
              end
            end
          end
          default: ;
        endcase
      end
    end
  end
  // frame timing: bit-time countdown, frame count and shared area write-back
  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_left_reg    <= 14'h0000;
      frame_count_reg   <= 16'h0000;
      running_d_reg     <= 1'b0;
      state_reg         <= S_IDLE;
      pend_reg          <= 1'b0;
      comm_write_req    <= 1'b0;
      comm_write_data   <= 16'h0000;
      sof_send          <= 1'b0;
      frame_start_flag  <= 1'b0;
      periodic_priority <= 1'b0;
      slow_start_ok     <= 1'b0;
    end else begin
      running_d_reg <= running_reg;
      sof_send      <= 1'b0;
      if (enter_run) begin
        frame_left_reg <= frame_period_reg;
      end else if (running_reg && bit_tick) begin
        frame_left_reg <= reload ? frame_period_reg : frame_left_reg - 14'd1;
      end
      if (reload || enter_run) begin
        frame_count_reg <= frame_count_reg + 16'd1;
        sof_send        <= 1'b1;
        pend_reg        <= 1'b1;
      end
      // periodic priority latched at the threshold but held off while a transfer runs
      if (reload || enter_run) begin
        periodic_priority <= 1'b0;
      end else if (running_reg && frame_left_reg <= periodic_start_reg && !xfer_busy) begin
        periodic_priority <= 1'b1;
      end
      slow_start_ok <= slow_request && running_reg && (frame_left_reg >= slow_threshold_reg);
      // software clears the start flag by writing one to status bit 0; a new set wins
      if (do_write && full_word && awaddr_reg == `OFS_STATUS && wdata_reg[0]) begin
        frame_start_flag <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (pend_reg && !sof_send) begin
            comm_write_req  <= 1'b1;
            comm_write_data <= frame_count_reg;
            pend_reg        <= 1'b0;
            state_reg       <= S_WBACK;
          end
        end
        S_WBACK: begin
          if (comm_write_done) begin
            comm_write_req   <= 1'b0;
            frame_start_flag <= 1'b1;
            state_reg        <= S_WAIT;
          end
        end
        S_WAIT: begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // read mux; reserved bits zero
  always @* begin
    rd_next = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `OFS_FRAME_COUNT:    rd_next[15:0] = frame_count_reg;
      `OFS_PERIODIC_START: rd_next[13:0] = periodic_start_reg;
      `OFS_SLOW_THRESHOLD: rd_next[11:0] = slow_threshold_reg;
      `OFS_FRAME_PERIOD:   rd_next[13:0] = frame_period_reg;
      `OFS_FRAME_LEFT:     rd_next[13:0] = frame_left_reg;
      `OFS_HUB_DESC_FIRST: begin
        rd_next[31:24]           = power_good_reg;
        rd_next[`BIT_OC_ABSENT]  = oc_absent_reg;
        rd_next[`BIT_OC_MODE]    = oc_mode_reg;
        rd_next[`BIT_COMPOUND]   = 1'b0;
        rd_next[`BIT_SWITCH_MODE] = switch_mode_reg;
        rd_next[`BIT_ALWAYS_ON]  = always_on_reg;
        rd_next[7:0]             = PORT_COUNT;
      end
      `OFS_CONTROL:   rd_next[0] = running_reg;
      `OFS_PORT_MASK: rd_next[PORTS:1] = mask_reg;
      `OFS_POWER_CMD: rd_next[PORTS+7:8] = port_power;
      `OFS_STATUS: begin
        rd_next[0] = frame_start_flag;
        rd_next[1] = periodic_priority;
      end
      default: rd_ok = 1'b0;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_next;
      s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* File: verilog/frame_timing_regs.vh */
// register offsets, field positions, reset values and timing counts for frame timing block
`ifndef FRAME_TIMING_REGS_VH
`define FRAME_TIMING_REGS_VH
`define OFS_FRAME_COUNT     12'h043c
`define OFS_PERIODIC_START  12'h0440
`define OFS_SLOW_THRESHOLD  12'h0444
`define OFS_HUB_DESC_FIRST  12'h0448
`define OFS_FRAME_PERIOD    12'h0434
`define OFS_FRAME_LEFT      12'h0438
`define OFS_CONTROL         12'h0460
`define OFS_POWER_CMD       12'h0464
`define OFS_PORT_MASK       12'h0468
`define OFS_STATUS          12'h046c
`define RST_FRAME_PERIOD    14'h2edf
`define RST_SLOW_THRESHOLD  12'h0628
`define RST_POWER_GOOD      8'h02
`define RST_OC_ABSENT       1'b1
`define RST_OC_MODE         1'b0
`define RST_SWITCH_MODE     1'b1
`define RST_ALWAYS_ON       1'b0
`define RST_PORT_COUNT      8'h01
`define BIT_OC_ABSENT       12
`define BIT_OC_MODE         11
`define BIT_COMPOUND        10
`define BIT_SWITCH_MODE     9
`define BIT_ALWAYS_ON       8
`define FULL_SPEED_KHZ      12000
`define CLOCK_KHZ           250000
`define BIT_TIME_CYCLES     (`CLOCK_KHZ / `FULL_SPEED_KHZ)
`define POWER_UNIT_MS       2
`endif
